// file: logic/pidt_params.svh
// Constants for the process-control core: codes, defaults and timing
`ifndef PIDT_PARAMS_SVH
`define PIDT_PARAMS_SVH
`define PIDT_CODE_TARGET 5'h09
`define PIDT_CODE_FEEDBACK 5'h08
`define PIDT_CODE_DIFF 5'h0A
`define PIDT_PULSE_FEEDBACK 5'h01
`define PIDT_PULSE_TARGET 5'h02
`define PIDT_PANEL_ON 1'h1
`define PIDT_BUS_TARGET_BIT 1
`define PIDT_BUS_CTRL_ADDR 16'h000F
`define PIDT_BUS_TARGET_ADDR 16'h0006
`define PIDT_DELAY_MAX 16'h7530
`define PIDT_DELAY_DEFAULT 16'h0000
`define PIDT_GAIN_MAX 12'h9C4
`define PIDT_GAIN_DEFAULT 12'h064
`define PIDT_GAIN_SCALE 32'h0000_0064
`define PIDT_MODE_DEFAULT 3'h0
`define PIDT_CLK_HZ 25000000
`define PIDT_TICK_S_DIV 10
`define PIDT_TICK_CYCLES (`PIDT_CLK_HZ / `PIDT_TICK_S_DIV)
`define PIDT_SAMPLE_US 1000
`define PIDT_SAMPLE_CYCLES ((`PIDT_CLK_HZ / 1000000) * `PIDT_SAMPLE_US)
`endif

// file: logic/pidt_pkg.sv
// Types shared by the process-control core
package pidt_pkg;
    typedef enum logic [2:0] {
        PIDT_MODE_OFF,
        PIDT_MODE_OUT1,
        PIDT_MODE_OUT2,
        PIDT_MODE_ADD1,
        PIDT_MODE_ADD2,
        PIDT_MODE_SLEEP
    } pidt_mode_e;
    typedef enum logic [1:0] {
        PIDT_TMR_OFF,
        PIDT_TMR_ARMING,
        PIDT_TMR_ON,
        PIDT_TMR_DISARMING
    } pidt_tmr_e;
endpackage

// file: logic/pidt_tick_if.sv
// Sample and tenth-second ticks passed from the tick generator to the core
`timescale 1ns/1ps
interface pidt_tick_if;
    logic sample;
    logic tenth;
    modport gen (output sample, output tenth);
    modport core (input sample, input tenth);
endinterface

// file: logic/pidt_tick_gen.sv
// Tick generator: control sample strobe and tenth-second strobe
`timescale 1ns/1ps
`include "pidt_params.svh"
module pidt_tick_gen
    import pidt_pkg::*;
#(
    parameter int SAMPLE_CYCLES = `PIDT_SAMPLE_CYCLES,
    parameter int TENTH_CYCLES = `PIDT_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Tick outputs
    pidt_tick_if.gen tick
);
    logic [31:0] samp_cnt_r;
    logic [31:0] tenth_cnt_r;
    wire samp_end = (samp_cnt_r == 32'(SAMPLE_CYCLES - 1));
    wire tenth_end = (tenth_cnt_r == 32'(TENTH_CYCLES - 1));

    // Free running counters, one pulse per period each
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            samp_cnt_r <= 32'h0000_0000;
            tenth_cnt_r <= 32'h0000_0000;
            tick.sample <= 1'b0;
            tick.tenth <= 1'b0;
        end else begin
            samp_cnt_r <= samp_end ? 32'h0000_0000 : samp_cnt_r + 32'h0000_0001;
            tenth_cnt_r <= tenth_end ? 32'h0000_0000 : tenth_cnt_r + 32'h0000_0001;
            tick.sample <= samp_end;
            tick.tenth <= tenth_end;
        end
    end
endmodule

// file: logic/pidt_core.sv
// Process-control core: on/off delay timer and PID controller
// Functional notes
// - Output on after input closed longer than delay
// - Output off after input open longer than delay
// - Delays 0 to 3000.0 s, default zero
// - P term is gain times deviation
// - I term accumulates deviation over time
// - D term adds time constant times slope
// - Target priority: A-in1, A-in2, pulse, panel, bus
// - Panel target used only when select equals one
// - Bus target active by control bit one
// - Both analog inputs target code: fault
// - Feedback priority: A-in1, A-in2, pulse coded one
// - Both analog inputs feedback code: fault
// - Code ten enables differential feedback
// - Two differential sources raise fault
// - Mode 0..5, modes 0 and 5 disable
// - Mode 1: output is controller, D on deviation
// - Mode 2: output is controller, D on feedback
// - Mode 3: command plus controller, D on deviation
// - Mode 4: command plus controller, D on feedback
// - Gain 0.00 to 25.00, default 1.00
`timescale 1ns/1ps
`include "pidt_params.svh"
module pidt_core
    import pidt_pkg::*;
#(
    parameter int DW = 16,
    parameter int SAMPLE_CYCLES = `PIDT_SAMPLE_CYCLES,
    parameter int TENTH_CYCLES = `PIDT_TICK_CYCLES,
    parameter int I_SHIFT = 10,
    parameter int D_SCALE = 1
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Delay timer
    input wire logic timer_input_i,
    input wire logic [15:0] timer_on_delay_i,
    input wire logic [15:0] timer_off_delay_i,
    output logic timer_output_o,
    // Source values
    input wire logic signed [DW-1:0] analog_input_one_i,
    input wire logic signed [DW-1:0] analog_input_two_i,
    input wire logic signed [DW-1:0] pulse_train_input_i,
    input wire logic signed [DW-1:0] panel_target_value_i,
    input wire logic [15:0] bus_ctrl_word_i,
    input wire logic signed [DW-1:0] bus_target_word_i,
    input wire logic signed [DW-1:0] freq_command_i,
    // Configuration
    input wire logic [4:0] analog_in_one_function_i,
    input wire logic [4:0] analog_in_two_function_i,
    input wire logic [4:0] pulse_in_function_i,
    input wire logic panel_target_select_i,
    input wire logic [2:0] pid_mode_select_i,
    input wire logic [11:0] proportional_gain_i,
    input wire logic [15:0] derivative_time_i,
    // Results and status
    output logic signed [DW-1:0] output_freq_o,
    output logic signed [DW-1:0] deviation_monitor_o,
    output logic signed [DW-1:0] second_feedback_monitor_o,
    output logic input_assignment_error_o,
    output logic pid_active_o,
    output logic sleep_wake_enable_o,
    output logic target_valid_o,
    output logic sample_done_o
);
    // Accumulator width: deviation times gain with room to spare
    localparam int AW = 2 * DW + 16;

    // Sample and tenth-second strobes shared with the tick generator
    pidt_tick_if tick_bus ();

    pidt_tick_gen #(
        .SAMPLE_CYCLES(SAMPLE_CYCLES),
        .TENTH_CYCLES(TENTH_CYCLES)
    ) u_tick (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .tick(tick_bus.gen)
    );

    // ---- Delay timer ----
    // Current state and count of tenth strobes seen in it
    pidt_tmr_e tmr_state_r;
    pidt_tmr_e tmr_state_nxt;
    logic [15:0] tmr_cnt_r;
    logic [15:0] tmr_cnt_nxt;
    // Clamp settings into range, zero is the default and means immediate
    wire [15:0] on_dly = (timer_on_delay_i > `PIDT_DELAY_MAX) ? `PIDT_DELAY_MAX
                                                               : timer_on_delay_i;
    wire [15:0] off_dly = (timer_off_delay_i > `PIDT_DELAY_MAX) ? `PIDT_DELAY_MAX
                                                                 : timer_off_delay_i;
    // Done once the tenth count reaches the delay; a zero delay switches
    // one cycle after the state change
    wire on_done = (tmr_cnt_r >= on_dly);
    wire off_done = (tmr_cnt_r >= off_dly);

    // Timer state: counts tenths while the input holds its new level
    always_comb begin
        tmr_state_nxt = tmr_state_r;
        tmr_cnt_nxt = tmr_cnt_r;
        case (tmr_state_r)
            PIDT_TMR_OFF: begin
                tmr_cnt_nxt = `PIDT_DELAY_DEFAULT;
                if (timer_input_i) begin
                    tmr_state_nxt = PIDT_TMR_ARMING;
                end
            end
            PIDT_TMR_ARMING: begin
                if (!timer_input_i) begin
                    tmr_state_nxt = PIDT_TMR_OFF;
                end else if (on_done) begin
                    tmr_state_nxt = PIDT_TMR_ON;
                end else if (tick_bus.tenth) begin
                    tmr_cnt_nxt = tmr_cnt_r + 16'h0001;
                end
            end
            PIDT_TMR_ON: begin
                tmr_cnt_nxt = `PIDT_DELAY_DEFAULT;
                if (!timer_input_i) begin
                    tmr_state_nxt = PIDT_TMR_DISARMING;
                end
            end
            PIDT_TMR_DISARMING: begin
                if (timer_input_i) begin
                    tmr_state_nxt = PIDT_TMR_ON;
                end else if (off_done) begin
                    tmr_state_nxt = PIDT_TMR_OFF;
                end else if (tick_bus.tenth) begin
                    tmr_cnt_nxt = tmr_cnt_r + 16'h0001;
                end
            end
            default: begin
                tmr_state_nxt = PIDT_TMR_OFF;
                tmr_cnt_nxt = `PIDT_DELAY_DEFAULT;
            end
        endcase
    end

    // Timer registers
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tmr_state_r <= PIDT_TMR_OFF;
            tmr_cnt_r <= `PIDT_DELAY_DEFAULT;
            timer_output_o <= 1'b0;
        end else begin
            tmr_state_r <= tmr_state_nxt;
            tmr_cnt_r <= tmr_cnt_nxt;
            // Output follows the next state so it moves with the state
            timer_output_o <= (tmr_state_nxt == PIDT_TMR_ON) ||
                              (tmr_state_nxt == PIDT_TMR_DISARMING);
        end
    end

    // ---- Source assignment decode ----
    // Each function code is compared once; the analog input flags feed both the
    // priority selectors and the conflict checks below, the pulse and panel flags only the selectors and the valid flag, the bus flag only the valid flag
    wire one_tgt = (analog_in_one_function_i == `PIDT_CODE_TARGET);
    wire two_tgt = (analog_in_two_function_i == `PIDT_CODE_TARGET);
    wire pls_tgt = (pulse_in_function_i == `PIDT_PULSE_TARGET);
    wire pn_tgt = (panel_target_select_i == `PIDT_PANEL_ON);
    wire bus_tgt = bus_ctrl_word_i[`PIDT_BUS_TARGET_BIT];

    // Normal feedback assignments
    wire one_fb = (analog_in_one_function_i == `PIDT_CODE_FEEDBACK);
    wire two_fb = (analog_in_two_function_i == `PIDT_CODE_FEEDBACK);
    wire pls_fb = (pulse_in_function_i == `PIDT_PULSE_FEEDBACK);

    // Differential feedback assignments
    wire one_df = (analog_in_one_function_i == `PIDT_CODE_DIFF);
    wire two_df = (analog_in_two_function_i == `PIDT_CODE_DIFF);

    // Faults on conflicting assignments; a clash also holds the controller off
    wire err_nxt = (one_tgt && two_tgt) ||
                   (one_fb && two_fb) ||
                   (one_df && two_df);

    // Target by fixed priority, first analog input highest
    // The bus word is the last resort, so with no source assigned the
    // controller still has a defined target, but the valid flag stays low unless the bus request bit is set
    wire signed [DW-1:0] target_sel =
        one_tgt ? analog_input_one_i :
        two_tgt ? analog_input_two_i :
        pls_tgt ? pulse_train_input_i :
        pn_tgt ? panel_target_value_i :
        bus_target_word_i;
    wire tgt_any = one_tgt || two_tgt || pls_tgt || pn_tgt || bus_tgt;

    // Feedback by fixed priority; zero when nothing is assigned
    wire signed [DW-1:0] fb_sel =
        one_fb ? analog_input_one_i :
        two_fb ? analog_input_two_i :
        pls_fb ? pulse_train_input_i :
        {DW{1'b0}};

    // Differential feedback, enabled by assignment alone
    wire diff_en = one_df || two_df;
    wire signed [DW-1:0] fb2_sel = one_df ? analog_input_one_i :
                                   two_df ? analog_input_two_i : {DW{1'b0}};
    // Effective feedback: the second signal is taken off the first when the
    // differential input is assigned, one bit wider so it cannot wrap
    wire signed [DW:0] fb_eff = diff_en ? ({fb_sel[DW-1], fb_sel} - {fb2_sel[DW-1], fb2_sel})
                                        : {fb_sel[DW-1], fb_sel};

    // Deviation, target minus effective feedback, two guard bits wide
    wire signed [DW+1:0] dev = {{2{target_sel[DW-1]}}, target_sel} -
                               {fb_eff[DW], fb_eff};

    // ---- Mode decode ----
    // Codes above the top mode read as the default, so a bad setting
    // leaves the controller off instead of running an undefined mode
    wire mode_ok = (pid_mode_select_i <= 3'(PIDT_MODE_SLEEP));
    wire [2:0] mode_raw = mode_ok ? pid_mode_select_i : `PIDT_MODE_DEFAULT;
    pidt_mode_e mode;
    assign mode = pidt_mode_e'(mode_raw);

    // Controller runs only in the four active modes and with no fault
    wire enable = (mode != PIDT_MODE_OFF) && (mode != PIDT_MODE_SLEEP) &&
                  !err_nxt;

    // Derivative source and frequency command use, per mode
    wire d_on_fb = (mode == PIDT_MODE_OUT2) || (mode == PIDT_MODE_ADD2);
    wire add_cmd = (mode == PIDT_MODE_ADD1) || (mode == PIDT_MODE_ADD2);

    // ---- PID arithmetic ----
    // All terms are formed at the accumulator width and cut only at the
    // output saturation, so the products cannot overflow
    logic signed [AW-1:0] integ_r;
    logic signed [DW+1:0] d_src_prev_r;

    // Gain in hundredths, clamped to the top of its range
    wire [11:0] gain = (proportional_gain_i > `PIDT_GAIN_MAX) ? `PIDT_GAIN_MAX
                                                               : proportional_gain_i;
    wire signed [AW-1:0] dev_w = AW'(dev);

    // Proportional term: deviation times gain, scaled back from hundredths
    wire signed [AW-1:0] p_term = (dev_w * $signed({1'b0, gain})) /
                                  $signed(AW'(`PIDT_GAIN_SCALE));

    // Derivative term: slope of the chosen source between two samples times
    // the derivative time; feedback is negated so both sources share a sign
    wire signed [DW+1:0] fb_as_src = -{fb_eff[DW], fb_eff};
    wire signed [DW+1:0] d_src = d_on_fb ? fb_as_src : dev;
    wire signed [AW-1:0] slope = AW'(d_src) - AW'(d_src_prev_r);
    wire signed [AW-1:0] d_term = (slope * $signed({1'b0, derivative_time_i})) /
                                  $signed(AW'(D_SCALE));

    // Integral term: running sum of the deviation, shifted down to scale
    wire signed [AW-1:0] integ_nxt = integ_r + dev_w;
    wire signed [AW-1:0] i_term = integ_r >>> I_SHIFT;

    // Controller sum, plus the frequency command in the adding modes
    wire signed [AW-1:0] pid_sum = p_term + i_term + d_term;
    wire signed [AW-1:0] out_sum = add_cmd ? (pid_sum + AW'(freq_command_i))
                                           : pid_sum;

    // Symmetric saturation to the output width
    wire signed [AW-1:0] sat_hi = AW'({1'b0, {(DW-1){1'b1}}});
    wire signed [AW-1:0] sat_lo = -sat_hi;
    wire signed [DW-1:0] out_sat = (out_sum > sat_hi) ? sat_hi[DW-1:0] :
                                   (out_sum < sat_lo) ? sat_lo[DW-1:0] :
                                   out_sum[DW-1:0];
    wire signed [DW-1:0] dev_sat = (dev_w > sat_hi) ? sat_hi[DW-1:0] :
                                   (dev_w < sat_lo) ? sat_lo[DW-1:0] : dev[DW-1:0];

    // Controller state and outputs, updated once per sample
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            integ_r <= '0;
            d_src_prev_r <= '0;
            output_freq_o <= '0;
            deviation_monitor_o <= '0;
            second_feedback_monitor_o <= '0;
            input_assignment_error_o <= 1'b0;
            pid_active_o <= 1'b0;
            sleep_wake_enable_o <= 1'b0;
            target_valid_o <= 1'b0;
            sample_done_o <= 1'b0;
        end else begin
            // Completion strobe marks the edge at which outputs refresh
            sample_done_o <= tick_bus.sample;
            if (tick_bus.sample) begin
                // Status follows the configuration seen at this sample
                input_assignment_error_o <= err_nxt;
                pid_active_o <= enable;
                sleep_wake_enable_o <= (mode == PIDT_MODE_SLEEP);
                target_valid_o <= tgt_any;
                deviation_monitor_o <= dev_sat;
                second_feedback_monitor_o <= fb2_sel;
                d_src_prev_r <= d_src;
                // A disabled or faulted controller passes the command through
                // and drops its integral, so it restarts without a kick
                if (enable) begin
                    integ_r <= integ_nxt;
                    output_freq_o <= out_sat;
                end else begin
                    integ_r <= '0;
                    output_freq_o <= freq_command_i;
                end
            end
        end
    end
endmodule

// file: test/pidt_src_model.sv
// Source side model: analog, pulse, panel and fieldbus values fed to the core
`timescale 1ns/1ps
module pidt_src_model
    import pidt_pkg::*;
(
    // Fieldbus master request
    input wire logic bus_on_i,
    // Readings and parameters
    output logic signed [15:0] in_one_o,
    output logic signed [15:0] in_two_o,
    output logic signed [15:0] pulse_o,
    output logic signed [15:0] panel_o,
    output logic [15:0] bus_ctrl_o,
    output logic signed [15:0] bus_tgt_o
);
    // Distinct fixed readings, so a wrong source pick shows at once
    assign in_one_o = 16'h0064;
    assign in_two_o = 16'h00C8;
    assign pulse_o = 16'h012C;
    assign panel_o = 16'h0190;
    // Master raises the target request bit and supplies the target word
    assign bus_ctrl_o = bus_on_i ? 16'h0002 : 16'h0000;
    assign bus_tgt_o = 16'h01F4;
endmodule

// file: test/pidt_core_sva.sv
// Checker for the process-control core ports
`timescale 1ns/1ps
module pidt_core_sva
    import pidt_pkg::*;
#(
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Watched signals
    input wire logic timer_input_i,
    input wire logic signed [DW-1:0] freq_command_i,
    input wire logic [4:0] analog_in_one_function_i,
    input wire logic [4:0] analog_in_two_function_i,
    input wire logic [2:0] pid_mode_select_i,
    input wire logic timer_output_o,
    input wire logic signed [DW-1:0] output_freq_o,
    input wire logic input_assignment_error_o,
    input wire logic pid_active_o,
    input wire logic sleep_wake_enable_o,
    input wire logic sample_done_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Code clashes between the two analog inputs must raise the fault
    property p_target_clash;
        (analog_in_one_function_i == 5'h09 && analog_in_two_function_i == 5'h09)[*4] ##0
            sample_done_o |-> input_assignment_error_o;
    endproperty
    a_target_clash: assert property (p_target_clash) else $error("no fault on target clash");
    property p_fb_clash;
        (analog_in_one_function_i == 5'h08 && analog_in_two_function_i == 5'h08)[*4] ##0
            sample_done_o |-> input_assignment_error_o;
    endproperty
    a_fb_clash: assert property (p_fb_clash) else $error("no fault on feedback clash");
    property p_diff_clash;
        (analog_in_one_function_i == 5'h0A && analog_in_two_function_i == 5'h0A)[*4] ##0
            sample_done_o |-> input_assignment_error_o;
    endproperty
    a_diff_clash: assert property (p_diff_clash) else $error("no fault on diff clash");
    // Disabled modes pass the command straight through
    property p_mode_off;
        ((pid_mode_select_i == 3'h0 || pid_mode_select_i == 3'h5) && $stable(freq_command_i))[*4]
            ##0 sample_done_o |-> output_freq_o == freq_command_i && !pid_active_o;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("disabled mode altered output");
    property p_mode_flags;
        ($stable(pid_mode_select_i))[*4] ##0 sample_done_o |->
            sleep_wake_enable_o == (pid_mode_select_i == 3'h5) && pid_active_o ==
            (pid_mode_select_i inside {[3'h1:3'h4]} && !input_assignment_error_o);
    endproperty
    a_mode_flags: assert property (p_mode_flags) else $error("mode flags wrong");
    // One update per sample period of eight cycles
    property p_done_gap;
        sample_done_o |=> !sample_done_o [*7] ##1 sample_done_o;
    endproperty
    a_done_gap: assert property (p_done_gap) else $error("sample pulse spacing wrong");
    // Timer output only follows a held input level
    property p_timer_on;
        $rose(timer_output_o) |-> $past(timer_input_i, 1) && $past(timer_input_i, 2);
    endproperty
    a_timer_on: assert property (p_timer_on) else $error("timer on without input");
    property p_timer_off;
        $fell(timer_output_o) |-> !$past(timer_input_i, 1) && !$past(timer_input_i, 2);
    endproperty
    a_timer_off: assert property (p_timer_off) else $error("timer off with input");
endmodule

bind pidt_core pidt_core_sva #(.DW(DW)) u_sva (
    .clock_i, .sys_rst_i, .timer_input_i, .freq_command_i, .analog_in_one_function_i,
    .analog_in_two_function_i, .pid_mode_select_i, .timer_output_o, .output_freq_o,
    .input_assignment_error_o, .pid_active_o, .sleep_wake_enable_o, .sample_done_o
);

// file: test/tb_pid_control_and_delay_timer.sv
// Self-checking bench for the process-control core
`timescale 1ns/1ps
module tb_pid_control_and_delay_timer
    import pidt_pkg::*;
;
    typedef struct packed {
        logic [4:0] fa, fb, fp;
        logic sel;
        logic [2:0] mode;
        logic err;
        logic [15:0] dev, out;
    } pidt_row_s;
    // Functions, panel select and mode beside the expected fault, deviation and output
    pidt_row_s rows [14] = '{
        '{5'h09, 5'h08, 5'h02, 1'h1, 3'h1, 1'h0, 16'hFF9C, 16'hFF9B},
        '{5'h09, 5'h09, 5'h02, 1'h1, 3'h1, 1'h1, 16'h0000, 16'h03E8},
        '{5'h08, 5'h09, 5'h02, 1'h1, 3'h3, 1'h0, 16'h0064, 16'h044C},
        '{5'h08, 5'h08, 5'h02, 1'h1, 3'h3, 1'h1, 16'h0000, 16'h03E8},
        '{5'h08, 5'h00, 5'h02, 1'h1, 3'h2, 1'h0, 16'h00C8, 16'h00C8},
        '{5'h00, 5'h00, 5'h01, 1'h1, 3'h0, 1'h0, 16'h0000, 16'h03E8},
        '{5'h00, 5'h00, 5'h01, 1'h1, 3'h4, 1'h0, 16'h0064, 16'h044C},
        '{5'h0A, 5'h0A, 5'h01, 1'h1, 3'h4, 1'h1, 16'h0000, 16'h03E8},
        '{5'h00, 5'h00, 5'h01, 1'h0, 3'h1, 1'h0, 16'h00C8, 16'h00C8},
        '{5'h00, 5'h00, 5'h01, 1'h0, 3'h5, 1'h0, 16'h0000, 16'h03E8},
        '{5'h08, 5'h0A, 5'h02, 1'h1, 3'h1, 1'h0, 16'h0190, 16'h0190},
        '{5'h08, 5'h08, 5'h01, 1'h1, 3'h0, 1'h1, 16'h0000, 16'h03E8},
        '{5'h08, 5'h00, 5'h02, 1'h1, 3'h6, 1'h0, 16'h00C8, 16'h03E8},
        '{5'h00, 5'h08, 5'h01, 1'h1, 3'h1, 1'h0, 16'h00C8, 16'h00C8}
    };
    logic clock_i, sys_rst_i, timer_input_i, sel, bus_on, tmr_out, fault, done, tvalid;
    logic [15:0] on_dly, off_dly, d_time, bus_ctrl;
    logic [4:0] fn_a, fn_b, fn_p;
    logic [2:0] mode;
    logic [11:0] gain;
    logic signed [15:0] in_one, in_two, pulse, panel, bus_tgt, freq_cmd, out_freq, dev;
    logic signed [15:0] fb2_mon, exp_f2;
    int errors, comparisons;
    // Clock at 25 MHz
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    // Far side sources and the unit under test
    pidt_src_model u_src (.bus_on_i(bus_on), .in_one_o(in_one), .in_two_o(in_two),
        .pulse_o(pulse), .panel_o(panel), .bus_ctrl_o(bus_ctrl), .bus_tgt_o(bus_tgt));
    pidt_core #(.SAMPLE_CYCLES(8), .TENTH_CYCLES(4)) u_dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .timer_input_i(timer_input_i),
        .timer_on_delay_i(on_dly), .timer_off_delay_i(off_dly), .timer_output_o(tmr_out),
        .analog_input_one_i(in_one), .analog_input_two_i(in_two), .pulse_train_input_i(pulse),
        .panel_target_value_i(panel), .bus_ctrl_word_i(bus_ctrl), .bus_target_word_i(bus_tgt),
        .freq_command_i(freq_cmd), .analog_in_one_function_i(fn_a),
        .analog_in_two_function_i(fn_b), .pulse_in_function_i(fn_p),
        .panel_target_select_i(sel), .pid_mode_select_i(mode), .proportional_gain_i(gain),
        .derivative_time_i(d_time), .output_freq_o(out_freq), .deviation_monitor_o(dev),
        .second_feedback_monitor_o(fb2_mon), .input_assignment_error_o(fault), .pid_active_o(),
        .sleep_wake_enable_o(), .target_valid_o(tvalid), .sample_done_o(done));
    // Compare one value and report a mismatch at once
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Wait for n sample pulses, bounded
    task automatic wait_done(input int n);
        int seen;
        int guard;
        seen = 0;
        guard = 0;
        while (seen < n && guard < 20 * n) begin
            @(negedge clock_i);
            guard++;
            seen += int'(done === 1'b1);
        end
        if (seen < n) begin
            errors++;
            $display("wrong value at %0t: sample pulse missing", $time);
        end
    endtask
    // Hold the timer input for n cycles, then look at the output
    task automatic step(input logic level, input int n, input logic exp);
        timer_input_i = level;
        repeat (n) @(negedge clock_i);
        check({15'h0000, tmr_out}, {15'h0000, exp}, "timer output");
    endtask
    // Print the counts and the verdict, then stop
    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog for a hung run
    initial begin
        #120000;
        errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        timer_input_i = 1'b0;
        {on_dly, off_dly, d_time, fn_a, fn_b, fn_p, sel, mode} = '0;
        gain = 12'h064;
        bus_on = 1'b1;
        freq_cmd = 16'h03E8;
        repeat (2) @(negedge clock_i);
        check(out_freq | {15'h0000, tmr_out | fault | done}, 16'h0000, "reset state");
        sys_rst_i = 1'b0;
        for (int i = 0; i < 14; i++) begin
            {fn_a, fn_b, fn_p, sel, mode} = {rows[i].fa, rows[i].fb, rows[i].fp, rows[i].sel,
                rows[i].mode};
            wait_done(2);
            check(out_freq, rows[i].out, "output frequency");
            check({15'h0000, fault}, {15'h0000, rows[i].err}, "fault");
            if (!rows[i].err && rows[i].mode inside {[3'h1:3'h4]}) begin
                check(dev, rows[i].dev, "deviation");
            end
            exp_f2 = (rows[i].fb == 5'h0A) ? in_two : 16'h0000;
            exp_f2 = (rows[i].fa == 5'h0A) ? in_one : exp_f2;
            check(fb2_mon, exp_f2, "second feedback");
        end
        gain = 12'h000;
        wait_done(40);
        check(out_freq, 16'h0008, "integral build-up");
        sel = 1'b0;
        d_time = 16'h0002;
        wait_done(1);
        check(out_freq, 16'h00D0, "derivative kick");
        wait_done(1);
        check(out_freq, 16'h0008, "derivative settle");
        on_dly = 16'h0002;
        off_dly = 16'h0003;
        step(1'b1, 3, 1'b0);
        step(1'b0, 12, 1'b0);
        step(1'b1, 3, 1'b0);
        step(1'b1, 12, 1'b1);
        step(1'b0, 3, 1'b1);
        step(1'b1, 2, 1'b1);
        step(1'b0, 3, 1'b1);
        step(1'b0, 14, 1'b0);
        on_dly = 16'h0000;
        step(1'b1, 3, 1'b1);
        bus_on = 1'b0;
        wait_done(2);
        check({15'h0000, tvalid}, 16'h0000, "target valid without request");
        bus_on = 1'b1;
        wait_done(2);
        check({15'h0000, tvalid}, 16'h0001, "target valid with request");
        mode = 3'h0;
        d_time = 16'h0000;
        gain = 12'hFFF;
        wait_done(2);
        mode = 3'h1;
        wait_done(1);
        check(out_freq, 16'h1D4C, "gain clamp");
        give_verdict();
    end
endmodule
